/* rtl/pcf_dev.sv */
// Drive end: pulse decoding, sources, gear and registers
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pcf_dev import pcf_pkg::*; #(
    parameter int STEP_CYCLES = STEP_CYC
) (
    input wire logic mclk, // Clock
    input wire logic rstn, // Sync reset, low
    pcf_if.drive lnk, // Pulse command lines
    input wire logic [7:0] avs_address, // Word index
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [31:0] avs_writedata, // Write data
    output logic [31:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Stall
    input wire logic gear_select_low, // Gear select input
    input wire logic gear_select_high, // Gear select input
    output logic signed [31:0] pos_cmd, // Command, encoder units
    output logic cmd_vld, // Scaled step pulse
    output logic signed [31:0] cmd_delta, // Scaled step
    output logic gear_fault, // Gear ratio fault
    output logic move_busy, // Step or internal move
    output logic irq // Interrupt, level
);
    logic [15:0] src_r;
    logic [15:0] form_r;
    logic [15:0] step_r;
    logic [31:0] upr_r;
    logic [31:0] den_r;
    logic [31:0] enc_r;
    logic [31:0] num_r [4];
    logic [31:0] tab_pos [16];
    logic [15:0] tab_spd [16];
    logic [15:0] tab_acc [16];
    logic [1:0] stat_r;
    logic [1:0] mask_r;
    logic ack_r;
    logic wr_ok;
    logic [3:0] s1_r;
    logic [3:0] s2_r;
    logic pa_r;
    logic pb_r;
    logic fault_d_r;
    logic signed [31:0] remain_r;
    logic [31:0] period_r;
    logic [31:0] tick_r;
    logic neg;
    logic a;
    logic b;
    logic [1:0] fam;
    logic p_vld;
    logic p_neg;
    logic i_vld;
    logic i_neg;
    logic g_vld;
    logic g_neg;
    logic [31:0] gnum;
    logic [31:0] gden;
    logic [1:0] gsel;
    logic signed [63:0] wd_s;
    logic signed [31:0] step_cl;
    logic done_ev;

    // ************************************************
    // Register bus
    // ************************************************
    // One wait cycle on each access
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
    assign wr_ok = avs_write & ack_r;

    always_ff @(posedge mclk) begin
        if (!rstn) ack_r <= 1'b0;
        else ack_r <= (avs_read | avs_write) & ~ack_r;
    end

    // Clamp the written step value to its range
    always_comb begin
        wd_s = $signed({{48{avs_writedata[15]}}, avs_writedata[15:0]});
        if (wd_s > $signed(STEP_LIM)) step_cl = 32'sd9999;
        else if (wd_s < -$signed(STEP_LIM)) step_cl = -32'sd9999;
        else step_cl = wd_s[31:0];
    end

    // Configuration writes
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            src_r <= SRC_RST;
            form_r <= FORM_RST;
            step_r <= 16'h0000;
            upr_r <= UPR_RST;
            den_r <= GEAR_RST;
            enc_r <= ENC_RST;
            mask_r <= 2'h0;
            for (int i = 0; i < 4; i++) num_r[i] <= GEAR_RST;
        end else if (wr_ok) begin
            if (avs_address == REG_SRC) src_r <= avs_writedata[15:0];
            else if (avs_address == REG_FORM)
                form_r <= avs_writedata[15:0];
            else if (avs_address == REG_STEP) step_r <= step_cl[15:0];
            else if (avs_address == REG_UPR) upr_r <= avs_writedata;
            else if (avs_address == REG_NUM1) num_r[0] <= avs_writedata;
            else if (avs_address == REG_NUM2) num_r[1] <= avs_writedata;
            else if (avs_address == REG_NUM3) num_r[2] <= avs_writedata;
            else if (avs_address == REG_NUM4) num_r[3] <= avs_writedata;
            else if (avs_address == REG_DEN) den_r <= avs_writedata;
            else if (avs_address == REG_ENC) enc_r <= avs_writedata;
            else if (avs_address == REG_MASK) mask_r <= avs_writedata[1:0];
        end
    end

    // Internal move table, no reset needed
    always_ff @(posedge mclk) begin
        if (wr_ok && avs_address[7:6] == TAB_PAGE) begin
            if (avs_address[1:0] == 2'h0)
                tab_pos[avs_address[5:2]] <= avs_writedata;
            else if (avs_address[1:0] == 2'h1)
                tab_spd[avs_address[5:2]] <= avs_writedata[15:0];
            else if (avs_address[1:0] == 2'h2)
                tab_acc[avs_address[5:2]] <= avs_writedata[15:0];
        end
    end

    // Read data captured with the acknowledge
    always_ff @(posedge mclk) begin
        if (!rstn) avs_readdata <= 32'h0;
        else if (avs_read && !ack_r) begin
            if (avs_address == REG_SRC) avs_readdata <= {16'h0, src_r};
            else if (avs_address == REG_FORM)
                avs_readdata <= {16'h0, form_r};
            else if (avs_address == REG_STEP)
                avs_readdata <= {{16{step_r[15]}}, step_r};
            else if (avs_address == REG_UPR) avs_readdata <= upr_r;
            else if (avs_address == REG_NUM1) avs_readdata <= num_r[0];
            else if (avs_address == REG_NUM2) avs_readdata <= num_r[1];
            else if (avs_address == REG_NUM3) avs_readdata <= num_r[2];
            else if (avs_address == REG_NUM4) avs_readdata <= num_r[3];
            else if (avs_address == REG_DEN) avs_readdata <= den_r;
            else if (avs_address == REG_ENC) avs_readdata <= enc_r;
            else if (avs_address == REG_STAT) avs_readdata <= {30'h0, stat_r};
            else if (avs_address == REG_MASK) avs_readdata <= {30'h0, mask_r};
            else if (avs_address == REG_POS) avs_readdata <= pos_cmd;
            else if (avs_address == REG_REMAIN) avs_readdata <= remain_r;
            else if (avs_address[7:6] == TAB_PAGE) begin
                if (avs_address[1:0] == 2'h0)
                    avs_readdata <= tab_pos[avs_address[5:2]];
                else if (avs_address[1:0] == 2'h1)
                    avs_readdata <= {16'h0, tab_spd[avs_address[5:2]]};
                else if (avs_address[1:0] == 2'h2)
                    avs_readdata <= {16'h0, tab_acc[avs_address[5:2]]};
                else avs_readdata <= 32'h0;
            end else avs_readdata <= 32'h0;
        end
    end

    // ************************************************
    // Pin synchronisers and pulse decoding
    // ************************************************
    genvar gi;
    for (gi = 0; gi < 4; gi++) begin : g_sync
        logic pin;
        assign pin = (gi == 0) ? lnk.line_a : (gi == 1) ? lnk.line_b :
                     (gi == 2) ? gear_select_low : gear_select_high;
        always_ff @(posedge mclk) begin
            if (!rstn) begin
                s1_r[gi] <= 1'b0;
                s2_r[gi] <= 1'b0;
            end else begin
                s1_r[gi] <= pin;
                s2_r[gi] <= s1_r[gi];
            end
        end
    end

    assign neg = form_r[0];
    assign fam = form_r[2:1];
    assign a = s2_r[0] ^ neg;
    assign b = s2_r[1] ^ neg;

    // Previous raw levels, so a form change makes no false edge
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pa_r <= 1'b0;
            pb_r <= 1'b0;
        end else begin
            pa_r <= s2_r[0];
            pb_r <= s2_r[1];
        end
    end

    // One command unit per decoded edge
    always_comb begin
        p_vld = 1'b0;
        p_neg = 1'b0;
        if (fam == FAM_DP) begin
            p_vld = a & ~(pa_r ^ neg);
            p_neg = ~b;
        end else if (fam == FAM_QUAD) begin
            p_vld = (s2_r[0] ^ pa_r) ^ (s2_r[1] ^ pb_r);
            p_neg = (s2_r[0] ^ pa_r) ? ~(a ^ b) : (a ^ b);
        end else if (fam == FAM_CW) begin
            p_vld = (a & ~(pa_r ^ neg)) ^ (b & ~(pb_r ^ neg));
            p_neg = b & ~(pb_r ^ neg);
        end
    end

    // ************************************************
    // Step and internal interpolator
    // ************************************************
    assign move_busy = (remain_r != 32'sh0);
    assign i_vld = move_busy && (tick_r + 32'h1 >= period_r);
    assign i_neg = remain_r[31];
    assign done_ev = i_vld && (remain_r == 32'sh1 || remain_r == -32'sh1);

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            remain_r <= 32'sh0;
            period_r <= 32'h1;
            tick_r <= 32'h0;
        end else if (wr_ok && avs_address == REG_STEP &&
                     src_r[1:0] == SRC_STEP) begin
            remain_r <= step_cl;
            period_r <= STEP_CYCLES;
            tick_r <= 32'h0;
        end else if (wr_ok && avs_address == REG_START &&
                     src_r[1:0] == SRC_INT) begin
            remain_r <= tab_pos[avs_writedata[3:0]];
            period_r <= (tab_spd[avs_writedata[3:0]] == 16'h0) ? 32'h1 :
                        {16'h0, tab_spd[avs_writedata[3:0]]};
            tick_r <= 32'h0;
        end else if (i_vld) begin
            remain_r <= i_neg ? remain_r + 32'sh1 : remain_r - 32'sh1;
            tick_r <= 32'h0;
        end else if (move_busy) tick_r <= tick_r + 32'h1;
    end

    // ************************************************
    // Gear selection, fault check and scaling
    // ************************************************
    assign gsel = s2_r[3:2];
    always_comb begin
        if (upr_r != 32'h0) begin
            gnum = enc_r;
            gden = upr_r;
        end else begin
            gnum = num_r[gsel];
            gden = den_r;
        end
        gear_fault = 1'b0;
        if (upr_r == 32'h0 && (gnum == 32'h0 || gnum > GEAR_MAX ||
            gden == 32'h0 || gden > GEAR_MAX)) gear_fault = 1'b1;
        if ({32'h0, gnum} * RES_LOW_DIV < {32'h0, enc_r} * {32'h0, gden} ||
            {32'h0, gnum} * 64'h5 > {31'h0, enc_r, 1'b0} * {32'h0, gden})
            gear_fault = 1'b1;
    end

    // Source mux feeds the scaler
    always_comb begin
        g_vld = 1'b0;
        g_neg = 1'b0;
        if (src_r[1:0] == SRC_PULSE) begin
            g_vld = p_vld;
            g_neg = p_neg;
        end else if (src_r[1:0] == SRC_STEP || src_r[1:0] == SRC_INT) begin
            g_vld = i_vld;
            g_neg = i_neg;
        end
        g_vld = g_vld & ~gear_fault;
    end

    pcf_gear u_gear (
        .mclk(mclk),
        .rstn(rstn),
        .in_vld(g_vld),
        .in_neg(g_neg),
        .num(gnum),
        .den(gden),
        .out_vld(cmd_vld),
        .out_delta(cmd_delta),
        .pos(pos_cmd)
    );

    // ************************************************
    // Sticky status and interrupt
    // ************************************************
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            stat_r <= 2'h0;
            fault_d_r <= 1'b0;
        end else begin
            fault_d_r <= gear_fault;
            for (int i = 0; i < 2; i++) begin
                if (wr_ok && avs_address == REG_STAT && avs_writedata[i])
                    stat_r[i] <= 1'b0;
            end
            if (gear_fault && !fault_d_r) stat_r[ST_FAULT] <= 1'b1;
            if (done_ev) stat_r[ST_DONE] <= 1'b1;
        end
    end

    assign irq = |(stat_r & mask_r);
endmodule
`default_nettype wire

/* rtl/pcf_pkg.sv */
// Constants and types of the position command front end
// Functional notes
// - Source code: 0 pulse, 1 step, 2 internal
// - Form 0/1: direction plus pulse, pos/neg
// - Form 2/3: quadrature pair, pos/neg logic
// - Form 4/5: forward and reverse lines
// - Step source moves -9999..9999 at low speed
// - Internal source: 16 position/speed/accel sets
// - Units setting nonzero: resolution over units setting
// - Units setting zero: numerator over denominator
// - Two select inputs pick one of four numerators
// - Output is in encoder resolution units
// - Ratio outside resolution window raises fault
// - Numerators and denominator are 1..2^30
package pcf_pkg;
    // ************************************************
    // Timing
    // ************************************************
    localparam int CLK_NS = 4;
    localparam int STEP_IVL_NS = 1000000;
    localparam int STEP_CYC = STEP_IVL_NS / CLK_NS;
    localparam int HALF_NS = 40;
    localparam int HALF_CYC = (HALF_NS + CLK_NS - 1) / CLK_NS;
    // ************************************************
    // Register word indices (byte address is four times)
    // ************************************************
    localparam logic [7:0] REG_SRC = 8'h05;
    localparam logic [7:0] REG_FORM = 8'h07;
    localparam logic [7:0] REG_UPR = 8'h08;
    localparam logic [7:0] REG_NUM1 = 8'h0A;
    localparam logic [7:0] REG_DEN = 8'h0C;
    localparam logic [7:0] REG_STEP = 8'h1A;
    localparam logic [7:0] REG_NUM2 = 8'h20;
    localparam logic [7:0] REG_NUM3 = 8'h21;
    localparam logic [7:0] REG_NUM4 = 8'h22;
    localparam logic [7:0] REG_ENC = 8'h23;
    localparam logic [7:0] REG_STAT = 8'h28;
    localparam logic [7:0] REG_MASK = 8'h29;
    localparam logic [7:0] REG_POS = 8'h2A;
    localparam logic [7:0] REG_START = 8'h2B;
    localparam logic [7:0] REG_REMAIN = 8'h2C;
    localparam logic [1:0] TAB_PAGE = 2'h1;
    // ************************************************
    // Fields and reset values
    // ************************************************
    localparam int ST_FAULT = 0;
    localparam int ST_DONE = 1;
    localparam logic [15:0] SRC_RST = 16'h0000;
    localparam logic [15:0] FORM_RST = 16'h0000;
    localparam logic [31:0] UPR_RST = 32'h0000_0000;
    localparam logic [31:0] GEAR_RST = 32'h0000_0001;
    localparam logic [31:0] ENC_RST = 32'h0002_0000;
    localparam logic [31:0] GEAR_MAX = 32'h4000_0000;
    localparam logic [63:0] RES_LOW_DIV = 64'h0000_0000_0098_9680;
    localparam logic [63:0] STEP_LIM = 64'h0000_0000_0000_270F;
    // ************************************************
    // Codes
    // ************************************************
    localparam logic [1:0] SRC_PULSE = 2'h0;
    localparam logic [1:0] SRC_STEP = 2'h1;
    localparam logic [1:0] SRC_INT = 2'h2;
    localparam logic [1:0] FAM_DP = 2'h0;
    localparam logic [1:0] FAM_QUAD = 2'h1;
    localparam logic [1:0] FAM_CW = 2'h2;
    typedef enum logic [2:0] {
        H_IDLE = 3'b001,
        H_ACT = 3'b010,
        H_REL = 3'b100
    } pcf_hstate_t;
endpackage

/* rtl/pcf_if.sv */
// Pulse command lines between controller and drive
`timescale 1ns/1ps
`default_nettype none
interface pcf_if;
    logic line_a;
    logic line_b;
    modport ctrl (output line_a, output line_b);
    modport drive (input line_a, input line_b);
endinterface
`default_nettype wire

/* rtl/pcf_gear.sv */
// Electronic gear scaler with carried remainder
`timescale 1ns/1ps
`default_nettype none
module pcf_gear import pcf_pkg::*; (
    input wire logic mclk, // Clock
    input wire logic rstn, // Sync reset, low
    input wire logic in_vld, // One input unit
    input wire logic in_neg, // Unit is reverse
    input wire logic [31:0] num, // Active numerator
    input wire logic [31:0] den, // Active denominator
    output logic out_vld, // Scaled step ready
    output logic signed [31:0] out_delta, // Scaled step
    output logic signed [31:0] pos // Accumulated command
);
    logic signed [63:0] rem_r;
    logic signed [63:0] prod;
    logic signed [63:0] dsafe;
    logic signed [63:0] quo;
    logic signed [63:0] modv;

    // Scale one unit and add the old remainder
    always_comb begin
        dsafe = (den == 32'h0) ? 64'sh1 : $signed({32'h0, den});
        prod = in_neg ? rem_r - $signed({32'h0, num})
                      : rem_r + $signed({32'h0, num});
        quo = prod / dsafe;
        modv = prod % dsafe;
    end

    // Remainder carry and position accumulation
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            rem_r <= 64'sh0;
            out_vld <= 1'b0;
            out_delta <= 32'sh0;
            pos <= 32'sh0;
        end else begin
            out_vld <= in_vld;
            if (in_vld) begin
                rem_r <= modv;
                out_delta <= quo[31:0];
                pos <= pos + quo[31:0];
            end
        end
    end
endmodule
`default_nettype wire

/* rtl/pcf_host.sv */
// Controller end: pulse train generator in six forms
`timescale 1ns/1ps
`default_nettype none
module pcf_host import pcf_pkg::*; #(
    parameter int HALF = HALF_CYC
) (
    input wire logic mclk, // Clock
    input wire logic rstn, // Sync reset, low
    pcf_if.ctrl lnk, // Pulse command lines
    input wire logic [2:0] form, // Pulse form code
    input wire logic cmd_valid, // Move request
    input wire logic signed [15:0] cmd_count, // Signed units
    output logic cmd_ready // Idle, request taken
);
    pcf_hstate_t st_r;
    logic [15:0] left_r;
    logic [31:0] cnt_r;
    logic dir_r;
    logic a_r;
    logic b_r;
    logic [1:0] ph_r;
    logic [1:0] ph_nxt;
    logic la_r;
    logic lb_r;
    logic neg;
    logic [1:0] fam;

    assign neg = form[0];
    assign fam = form[2:1];
    assign cmd_ready = (st_r == H_IDLE);
    assign ph_nxt = dir_r ? ph_r - 2'h1 : ph_r + 2'h1;

    // Sequencer: one unit is an active half and a release half
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            st_r <= H_IDLE;
            left_r <= 16'h0;
            cnt_r <= 32'h0;
            dir_r <= 1'b0;
            a_r <= 1'b0;
            b_r <= 1'b0;
            ph_r <= 2'h0;
        end else begin
            case (st_r)
                H_IDLE: begin
                    if (cmd_valid && cmd_count != 16'sh0) begin
                        left_r <= cmd_count[15] ? 16'(-cmd_count) : cmd_count;
                        dir_r <= cmd_count[15];
                        cnt_r <= 32'h0;
                        st_r <= H_ACT;
                    end
                end
                H_ACT: begin
                    if (cnt_r == 32'h0) begin
                        if (fam == FAM_DP) begin
                            a_r <= 1'b1;
                            b_r <= ~dir_r;
                        end else if (fam == FAM_QUAD) ph_r <= ph_nxt;
                        else if (dir_r) b_r <= 1'b1;
                        else a_r <= 1'b1;
                    end
                    if (cnt_r + 32'h1 >= HALF) begin
                        cnt_r <= 32'h0;
                        st_r <= H_REL;
                    end else cnt_r <= cnt_r + 32'h1;
                end
                H_REL: begin
                    a_r <= 1'b0;
                    if (fam != FAM_DP) b_r <= 1'b0;
                    if (cnt_r + 32'h1 >= HALF) begin
                        cnt_r <= 32'h0;
                        left_r <= left_r - 16'h1;
                        st_r <= (left_r == 16'h1) ? H_IDLE : H_ACT;
                    end else cnt_r <= cnt_r + 32'h1;
                end
                default: st_r <= H_IDLE;
            endcase
        end
    end

    // Line levels with polarity applied
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            la_r <= 1'b0;
            lb_r <= 1'b0;
        end else if (fam == FAM_QUAD) begin
            la_r <= (ph_r[1] ^ ph_r[0]) ^ neg;
            lb_r <= ph_r[1] ^ neg;
        end else begin
            la_r <= a_r ^ neg;
            lb_r <= b_r ^ neg;
        end
    end

    assign lnk.line_a = la_r;
    assign lnk.line_b = lb_r;
endmodule
`default_nettype wire

/* test/pcf_properties.sv */
// Checker of the pulse lines and scaled results
`timescale 1ns/1ps
`default_nettype none
module pcf_properties (
    input wire logic mclk, // Clock
    input wire logic rstn, // Reset, low
    input wire logic line_a, // Line A
    input wire logic line_b, // Line B
    input wire logic [2:0] form, // Form code
    input wire logic cmd_ready, // Host idle
    input wire logic cmd_vld, // Scaled step
    input wire logic gear_fault // Ratio fault
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    logic [2:0] f1_r;
    logic [2:0] f2_r;
    logic steady;
    // Form code history
    always_ff @(posedge mclk) begin
        f1_r <= form;
        f2_r <= f1_r;
    end
    assign steady = form == f1_r && f1_r == f2_r;
    // ************
    // Properties
    // ************
    property p_dp_idle;
        steady && form == 3'h0 && cmd_ready |-> !line_a;
    endproperty
    a_dp_idle: assert property (p_dp_idle) else $error("A not low");
    property p_dn_idle;
        steady && form == 3'h1 && cmd_ready |-> line_a;
    endproperty
    a_dn_idle: assert property (p_dn_idle) else $error("A not high");
    property p_half;
        $rose(line_a) && form == 3'h0 |-> line_a [*8];
    endproperty
    a_half: assert property (p_half) else $error("A too short");
    property p_quad;
        steady && form == 3'h2 && $changed(line_a) |-> $stable(line_b);
    endproperty
    a_quad: assert property (p_quad) else $error("both moved");
    property p_cw;
        steady && form == 3'h4 |-> !(line_a && line_b);
    endproperty
    a_cw: assert property (p_cw) else $error("both lines high");
    property p_cwn_idle;
        steady && form == 3'h5 && cmd_ready |-> line_a && line_b;
    endproperty
    a_cwn_idle: assert property (p_cwn_idle) else $error("not idle");
    property p_count;
        $rose(line_a) && steady && form == 3'h0 && !gear_fault
            |-> ##[1:8] cmd_vld;
    endproperty
    a_count: assert property (p_count) else $error("no count");
    property p_busy;
        $fell(cmd_ready) |-> !cmd_ready [*8];
    endproperty
    a_busy: assert property (p_busy) else $error("unit too short");
    c_step: cover property (cmd_vld);
    c_fault: cover property (gear_fault);
    c_quad: cover property (steady && form == 3'h2 && $changed(line_a));
endmodule
`default_nettype wire

/* test/position_command_front_end_test.sv */
// Bench joining controller and drive ends
`timescale 1ns/1ps
`default_nettype none
module position_command_front_end_test import pcf_pkg::*;;
    logic mclk = 1'h0, rstn = 1'h0, rd = 1'h0, wr = 1'h0;
    logic vld = 1'h0, gsl = 1'h0, gsh = 1'h0;
    logic [7:0] adr = '0;
    logic [31:0] wd = '0, rdat, q;
    logic [2:0] form = '0;
    logic signed [15:0] cnt = '0;
    logic signed [31:0] pos, dlt;
    logic wt, cv, gf, mb, irq, rdy;
    int err_count = 0, n_compared = 0, seed = 32'h9F0F, cyc = 0, n, dir;
    longint gn, gd, sum, prv, nev;
    logic [7:0] ra [4] = '{REG_SRC, REG_FORM, REG_NUM1, 8'h30};
    logic [31:0] rv [4] = '{32'h0, 32'h0, 32'h1, 32'h0};
    pcf_if lnk ();
    pcf_host #(.HALF(10)) u_pcf_host (.mclk(mclk), .rstn(rstn),
        .lnk(lnk.ctrl), .form(form), .cmd_valid(vld), .cmd_count(cnt),
        .cmd_ready(rdy));
    pcf_dev #(.STEP_CYCLES(4)) u_pcf_dev (.mclk(mclk), .rstn(rstn),
        .lnk(lnk.drive), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wt),
        .gear_select_low(gsl), .gear_select_high(gsh), .pos_cmd(pos),
        .cmd_vld(cv), .cmd_delta(dlt), .gear_fault(gf), .move_busy(mb),
        .irq(irq));
    pcf_properties u_pcf_properties (.mclk(mclk), .rstn(rstn),
        .line_a(lnk.line_a), .line_b(lnk.line_b), .form(form),
        .cmd_ready(rdy), .cmd_vld(cv), .gear_fault(gf));
    // Clock and run limit
    initial begin
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            err_count++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Bus access held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge mclk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        do @(posedge mclk); while (wt !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic reset_all();
        @(posedge mclk);
        rstn <= 1'b0;
        form <= 3'h0;
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        sum = 0;
        prv = 0;
        nev = 0;
        gn = 1;
        gd = 1;
    endtask
    // One host move, form settled first
    task automatic move(input logic [2:0] f, input int c);
        form <= f;
        repeat (4) @(posedge mclk);
        dir = c < 0 ? -1 : 1;
        cnt <= 16'(c);
        vld <= 1'b1;
        do @(posedge mclk); while (rdy !== 1'b1);
        vld <= 1'b0;
        do @(posedge mclk); while (rdy !== 1'b1);
        repeat (12) @(posedge mclk);
    endtask
    // Reference model checked at every scaled step
    always @(posedge mclk) begin
        if (rstn && cv === 1'b1) begin
            sum = sum + dir;
            nev = nev + 1;
            chk("pos", 32'(gn * sum / gd), pos);
            chk("delta", 32'(gn * sum / gd - prv), dlt);
            prv = gn * sum / gd;
        end
    end
    initial begin
        reset_all();
        foreach (ra[i]) begin
            bus(1'b0, ra[i], '0);
            chk("reset value", rv[i], q);
        end
        $display("registers done");
        for (int k = 0; k < 6; k++) begin
            gsl <= k[0];
            gsh <= k[1];
            reset_all();
            bus(1'b1, REG_NUM2, 32'h3);
            bus(1'b1, REG_NUM3, 32'h5);
            bus(1'b1, REG_NUM4, 32'h7);
            bus(1'b1, REG_DEN, 32'h2);
            bus(1'b1, REG_FORM, 32'(k));
            gn = 2 * (k % 4) + 1;
            gd = 2;
            n = $unsigned($random(seed)) % 6 + 1;
            move(3'(k), k[0] ? -n : n);
            chk("events", 32'(n), 32'(nev));
            $display("form %0d done", k);
        end
        gsl <= 1'b0;
        gsh <= 1'b0;
        reset_all();
        bus(1'b1, REG_UPR, 32'h3E8);
        gn = ENC_RST;
        gd = 1000;
        move(3'h0, 5);
        $display("units per turn done");
        reset_all();
        bus(1'b1, REG_NUM1, 32'hEA60);
        @(posedge mclk);
        chk("fault high", 32'h1, 32'(gf));
        move(3'h0, 2);
        chk("blocked", 32'h0, 32'(nev));
        bus(1'b1, REG_NUM1, 32'h1);
        bus(1'b1, REG_DEN, 32'h64);
        @(posedge mclk);
        chk("fault low", 32'h1, 32'(gf));
        bus(1'b1, REG_DEN, 32'h1);
        @(posedge mclk);
        chk("fault clear", 32'h0, 32'(gf));
        bus(1'b0, REG_STAT, '0);
        chk("fault flag", 32'h1, q & 32'h1);
        $display("fault done");
        reset_all();
        bus(1'b1, REG_SRC, 32'h1);
        dir = 1;
        bus(1'b1, REG_STEP, 32'h2EE0);
        repeat (3) @(posedge mclk);
        while (mb === 1'b1) @(posedge mclk);
        repeat (4) @(posedge mclk);
        chk("step clamp", 32'h270F, 32'(nev));
        chk("irq masked", 32'h0, 32'(irq));
        bus(1'b0, REG_STAT, '0);
        chk("done flag", 32'h2, q & 32'h2);
        bus(1'b1, REG_MASK, 32'h2);
        @(posedge mclk);
        chk("irq set", 32'h1, 32'(irq));
        bus(1'b1, REG_STAT, 32'h2);
        @(posedge mclk);
        chk("irq clear", 32'h0, 32'(irq));
        $display("step done");
        reset_all();
        bus(1'b1, REG_SRC, 32'h2);
        bus(1'b1, 8'h40, 32'hFFFF_FFFD);
        bus(1'b1, 8'h41, 32'h2);
        dir = -1;
        bus(1'b1, REG_START, 32'h0);
        repeat (20) @(posedge mclk);
        chk("table moves", 32'h3, 32'(nev));
        chk("table pos", 32'hFFFF_FFFD, pos);
        $display("table done");
        complete_run();
    end
endmodule
`default_nettype wire
